/* core/scc_regs.svh */
// register offsets, field positions, reset values and masks for the
// system clock and reset configuration block; definitions only
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

`define SCC_OFF_PSC 8'hF0
`define SCC_OFF_REL 8'hF4
`define SCC_OFF_STRAP 8'hF6
`define SCC_OFF_RELOC 8'hFE

`define SCC_PSC_RESET 16'h0000
`define SCC_PSC_MASK 16'hCF07
`define SCC_RELOC_RESET 16'h20FF
`define SCC_RELOC_MASK 16'h5FFF
`define SCC_RELOC_FIXED 16'h2000

`define SCC_PSC_SAVE_EN 15
`define SCC_PSC_MCSFULL 14
`define SCC_PSC_B_FREQ 11
`define SCC_PSC_B_OFF 10
`define SCC_PSC_A_FREQ 9
`define SCC_PSC_A_OFF 8
`define SCC_RELOC_SLAVE 14
`define SCC_RELOC_MEM 12

`endif

/* core/scc_pkg.sv */
// types shared by the system clock and reset configuration block
package scc_pkg;
    typedef enum logic [0:0] {
        SCC_STRAP_WAIT = 1'b0,
        SCC_STRAP_DONE = 1'b1
    } scc_strap_e;
    typedef logic [15:0] scc_word_t;
endpackage

/* core/scc_top.sv */
// system configuration: control block placement, release level, power-save
// clock divider, clock output pins and reset strap capture.
// assumes all inputs are synchronous to mclk and registers are reached by a
// simple select/write strobe port at the block's own offsets.
// Overview of operation
// - space bit 12 picks memory or io
// - base bits 11-0 give address 19-8
// - bit 14 picks interrupt slave role
// - chip select overlap needs fast config
// - release register reads version and ident
// - power-save divides internal clock by code
// - external interrupt clears power-save enable
// - software interrupts leave power-save alone
// - divisor code gives two to power
// - full-range bit widens first midrange select
// - bit 11 picks clock b source
// - bit 9 picks clock a source
// - drive-off bits float clock pins
// - bus levels latched at reset release
// - both memory straps low float pins
// - halving strap low divides clock by two
// - address strap low omits address phase
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_top
    import scc_pkg::*;
#(
    parameter logic [7:0] RELEASE_VERSION = 8'h11, // arbitrary value
    parameter logic [7:0] MAKER_IDENT = 8'h5A // arbitrary value
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic ext_irq,
    input wire logic [15:0] muxed_addr_data_bus,
    input wire logic upper_mem_select_strap,
    input wire logic lower_mem_select_strap,
    input wire logic clock_halving_strap,
    input wire logic address_phase_strap,
    input wire logic [19:0] bus_addr,
    input wire logic bus_mem,
    input wire logic per_sel_hit,
    input wire logic per_sel_zero_wait,
    input wire logic per_sel_no_ready,
    input wire logic mid_sel_first_hit,
    input wire logic mid_sel_range_hit,
    input wire logic mid_sel_zero_wait,
    input wire logic mid_sel_no_ready,
    output logic peripheral_ctrl_block_hit,
    output logic per_sel_act,
    output logic midrange_select_first,
    output logic icu_slave_mode,
    output logic cpu_clk_en,
    output logic clock_out_a,
    output logic clock_out_a_oe,
    output logic clock_out_b,
    output logic clock_out_b_oe,
    output logic all_pins_float_test,
    output logic address_phase_omit,
    output logic strap_valid
);
    scc_word_t psc_reg;
    scc_word_t reloc_reg;
    scc_word_t strap_capture_word;
    scc_word_t rd_next;
    scc_strap_e strap_state;
    logic halve_reg;
    logic [3:0] shift_reg;
    logic [3:0] shift_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_term;
    logic [1:0] co_reg;
    logic [1:0] oe_reg;
    logic [11:0] block_base_bits;
    logic power_save_enable;
    logic wr_psc;
    logic wr_reloc;
    logic in_block;

    assign power_save_enable = psc_reg[`SCC_PSC_SAVE_EN];
    assign block_base_bits = reloc_reg[11:0];
    assign wr_psc = reg_sel && reg_wr && (reg_addr == `SCC_OFF_PSC);
    assign wr_reloc = reg_sel && reg_wr && (reg_addr == `SCC_OFF_RELOC);

    // power-save control register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            psc_reg <= `SCC_PSC_RESET;
        end else begin
            if (wr_psc) begin
                psc_reg <= reg_wdata & `SCC_PSC_MASK;
            end
            // ext_irq, or a write with bit 15 low, clears it
            // interrupt beats a same-cycle write so the cpu wakes even if that write sets power-save
            if (ext_irq) begin
                psc_reg[`SCC_PSC_SAVE_EN] <= 1'b0;
            end
        end
    end

    // relocation register; reserved bit 13 reads as one
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reloc_reg <= `SCC_RELOC_RESET;
        end else if (wr_reloc) begin
            reloc_reg <= (reg_wdata & `SCC_RELOC_MASK) | `SCC_RELOC_FIXED;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            `SCC_OFF_PSC: rd_next = psc_reg;
            `SCC_OFF_REL: rd_next = {RELEASE_VERSION, MAKER_IDENT};
            `SCC_OFF_STRAP: rd_next = strap_capture_word;
            `SCC_OFF_RELOC: rd_next = reloc_reg;
            default: rd_next = 16'h0000;
        endcase
    end

    // read data holds until the next read
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (reg_sel && !reg_wr) begin
            reg_rdata <= rd_next;
        end
    end

    // strap capture on the first edge after reset release
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            strap_state <= SCC_STRAP_WAIT;
            strap_capture_word <= 16'h0000;
            strap_valid <= 1'b0;
            all_pins_float_test <= 1'b0;
            halve_reg <= 1'b0;
            address_phase_omit <= 1'b0;
        end else begin
            unique case (strap_state)
                SCC_STRAP_WAIT: begin
                    strap_capture_word <= muxed_addr_data_bus;
                    all_pins_float_test <= !upper_mem_select_strap && !lower_mem_select_strap;
                    halve_reg <= !clock_halving_strap;
                    address_phase_omit <= !address_phase_strap;
                    strap_valid <= 1'b1;
                    strap_state <= SCC_STRAP_DONE;
                end
                SCC_STRAP_DONE: begin
                    strap_state <= SCC_STRAP_DONE;
                end
            endcase
        end
    end

    assign shift_next = (power_save_enable ? {1'b0, psc_reg[2:0]} : 4'h0)
        + {3'b000, halve_reg};
    assign cnt_term = 8'((16'h0001 << shift_reg) - 16'h0001);

    // internal clock enable divider
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 8'h00;
            shift_reg <= 4'h0;
            cpu_clk_en <= 1'b0;
        end else if (cnt_reg == cnt_term) begin
            cnt_reg <= 8'h00;
            shift_reg <= shift_next;
            cpu_clk_en <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            cpu_clk_en <= 1'b0;
        end
    end

    // clock output pins; crystal mode toggles every mclk, so both pins show
    // half the selected rate, the fastest a flop can make
    for (genvar i = 0; i < 2; i++) begin : g_clkout
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                co_reg[i] <= 1'b0;
                oe_reg[i] <= 1'b0;
            end else begin
                if (psc_reg[`SCC_PSC_A_FREQ + 2 * i] || cpu_clk_en) begin
                    co_reg[i] <= !co_reg[i];
                end
                // drive off floats pin
                // wait for the straps so test mode never drives a pin for a cycle
                oe_reg[i] <= strap_valid && !psc_reg[`SCC_PSC_A_OFF + 2 * i]
                    && !all_pins_float_test;
            end
        end
    end
    assign clock_out_a = co_reg[0];
    assign clock_out_b = co_reg[1];
    assign clock_out_a_oe = oe_reg[0];
    assign clock_out_b_oe = oe_reg[1];

    // space bit picks io or memory
    // io base has top bits zero
    assign in_block = (bus_addr[19:8] == block_base_bits)
        && (bus_mem == reloc_reg[`SCC_RELOC_MEM]);

    // decode and role outputs
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            peripheral_ctrl_block_hit <= 1'b0;
            per_sel_act <= 1'b0;
            midrange_select_first <= 1'b0;
            icu_slave_mode <= 1'b0;
        end else begin
            peripheral_ctrl_block_hit <= in_block;
            per_sel_act <= per_sel_hit
                && (!in_block || (per_sel_zero_wait && per_sel_no_ready));
            midrange_select_first <= (psc_reg[`SCC_PSC_MCSFULL] ? mid_sel_range_hit
                : mid_sel_first_hit)
                && (!in_block || (mid_sel_zero_wait && mid_sel_no_ready));
            icu_slave_mode <= reloc_reg[`SCC_RELOC_SLAVE];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_gap3;
        !cpu_clk_en [*3] ##1 cpu_clk_en;
    endsequence

    property p_irq_wake;
        ext_irq |=> !psc_reg[`SCC_PSC_SAVE_EN];
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("irq kept power-save");

    property p_power_save_enable_hold;
        !ext_irq && !wr_psc |=> $stable(psc_reg[`SCC_PSC_SAVE_EN]);
    endproperty
    a_power_save_enable_hold: assert property (p_power_save_enable_hold) else $error("power-save moved");

    property p_div4;
        cpu_clk_en && shift_reg == 4'h2 |=> s_gap3;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four wrong");

    property p_boundary;
        $changed(shift_reg) |-> cpu_clk_en;
    endproperty
    a_boundary: assert property (p_boundary) else $error("divider changed mid period");

    property p_map;
        in_block |=> peripheral_ctrl_block_hit;
    endproperty
    a_map: assert property (p_map) else $error("block decode missed");

    property p_overlap;
        per_sel_hit && in_block && !per_sel_zero_wait |=> !per_sel_act;
    endproperty
    a_overlap: assert property (p_overlap) else $error("slow select overlapped");

    property p_full_range;
        psc_reg[`SCC_PSC_MCSFULL] && mid_sel_range_hit && !in_block |=> midrange_select_first;
    endproperty
    a_full_range: assert property (p_full_range) else $error("full range missed");

    property p_b_off;
        psc_reg[`SCC_PSC_B_OFF] |=> !clock_out_b_oe;
    endproperty
    a_b_off: assert property (p_b_off) else $error("clock b still driven");

    property p_strap_hold;
        strap_valid |=> $stable(strap_capture_word) && strap_valid;
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap word changed");

    property p_release;
        reg_sel && !reg_wr && reg_addr == `SCC_OFF_REL
            |=> reg_rdata == {RELEASE_VERSION, MAKER_IDENT};
    endproperty
    a_release: assert property (p_release) else $error("release level wrong");
endmodule

/* bench/system_clock_reset_config_bench.sv */
// self-checking bench for the system clock and reset configuration block.
// assumes scc_top with its registers at the offsets in scc_regs.svh.
`timescale 1ns/1ps
`include "scc_regs.svh"
module system_clock_reset_config_bench;
    localparam logic [7:0] VER = 8'h3C; // arbitrary value
    localparam logic [7:0] IDENT = 8'hA7; // arbitrary value
    logic mclk, rst_b, reg_sel, reg_wr, ext_irq, rd_d;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, strap, muxed_addr_data_bus;
    logic ums, lms, halve, aph, bus_mem, phit, pzw, pnr, mfirst, mrange, mzw, mnr;
    logic [19:0] bus_addr;
    logic peripheral_ctrl_block_hit, per_sel_act, mid_first, icu_slave_mode, cpu_clk_en;
    logic clock_out_a, clock_out_a_oe, clock_out_b, clock_out_b_oe;
    logic all_pins_float_test, address_phase_omit, strap_valid;
    logic [15:0] q[$];
    int mismatches = 0, checks = 0, cycles = 0;

    scc_top #(.RELEASE_VERSION(VER), .MAKER_IDENT(IDENT)) i_scc_top (
        .mclk(mclk), .rst_b(rst_b), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ext_irq(ext_irq), .muxed_addr_data_bus(muxed_addr_data_bus),
        .upper_mem_select_strap(ums), .lower_mem_select_strap(lms),
        .clock_halving_strap(halve), .address_phase_strap(aph), .bus_addr(bus_addr),
        .bus_mem(bus_mem), .per_sel_hit(phit), .per_sel_zero_wait(pzw),
        .per_sel_no_ready(pnr), .mid_sel_first_hit(mfirst), .mid_sel_range_hit(mrange),
        .mid_sel_zero_wait(mzw), .mid_sel_no_ready(mnr),
        .peripheral_ctrl_block_hit(peripheral_ctrl_block_hit),
        .per_sel_act(per_sel_act), .midrange_select_first(mid_first),
        .icu_slave_mode(icu_slave_mode), .cpu_clk_en(cpu_clk_en),
        .clock_out_a(clock_out_a), .clock_out_a_oe(clock_out_a_oe),
        .clock_out_b(clock_out_b), .clock_out_b_oe(clock_out_b_oe),
        .all_pins_float_test(all_pins_float_test),
        .address_phase_omit(address_phase_omit), .strap_valid(strap_valid));

    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard, well above the longest divider sweep
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            end_of_test();
        end
    end

    // read data stands from the taking edge on and is checked at the next falling edge
    always @(posedge mclk) rd_d <= reg_sel && !reg_wr;
    always @(negedge mclk) begin
        if (rd_d)
            check(reg_rdata, (q.size() > 0) ? q.pop_front() : 16'hDEAD);
    end

    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_sel <= 1'b1;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_sel <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        q.push_back(exp);
        access(1'b0, a, 16'h0000);
    endtask

    // straps must hold through the first edge after release
    task automatic do_reset(input logic [15:0] w, input logic s);
        @(posedge mclk);
        rst_b <= 1'b0;
        muxed_addr_data_bus <= w;
        {ums, lms, halve, aph} <= {4{s}};
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    // decode outputs land one cycle after their inputs
    task automatic dec(input logic [19:0] a, input logic m, input logic [1:0] c,
                       input logic [2:0] exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_mem <= m;
        {pzw, pnr, mzw, mnr} <= {c, c};
        @(posedge mclk);
        @(negedge mclk);
        check({peripheral_ctrl_block_hit, per_sel_act, mid_first}, exp);
    endtask

    task automatic wait_en;
        int k;
        k = 0;
        @(negedge mclk);
        while (cpu_clk_en !== 1'b1 && k < 300) begin
            @(negedge mclk);
            k++;
        end
    endtask

    // a fresh setting only shows from the second pulse on
    task automatic period(input int expn);
        int n;
        wait_en();
        wait_en();
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (cpu_clk_en !== 1'b1 && n < 300);
        check(16'(n), 16'(expn));
    endtask

    task automatic toggles(input int ea, input int eb);
        logic pa, pb;
        int ta, tb;
        ta = 0;
        tb = 0;
        @(negedge mclk);
        pa = clock_out_a;
        pb = clock_out_b;
        repeat (16) begin
            @(negedge mclk);
            ta += int'(clock_out_a !== pa);
            tb += int'(clock_out_b !== pb);
            pa = clock_out_a;
            pb = clock_out_b;
        end
        check(16'(ta), 16'(ea));
        check(16'(tb), 16'(eb));
    endtask

    initial begin
        {rst_b, reg_sel, reg_wr, ext_irq, bus_mem, pzw, pnr, mzw, mnr} = '0;
        {ums, lms, halve, aph, phit, mfirst, mrange} = '1;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        bus_addr = 20'h00000;
        muxed_addr_data_bus = 16'h0000;
        void'($urandom(32'h7D87));
        strap = 16'($urandom());
        do_reset(strap, 1'b1);
        rd(`SCC_OFF_PSC, 16'h0000);
        rd(`SCC_OFF_RELOC, 16'h20FF);
        rd(`SCC_OFF_REL, {VER, IDENT});
        rd(`SCC_OFF_STRAP, strap);
        rd(8'hF2, 16'h0000);
        check({all_pins_float_test, address_phase_omit, strap_valid}, 3'b001);
        // read-only places refuse writes
        access(1'b1, `SCC_OFF_REL, 16'hFFFF);
        access(1'b1, `SCC_OFF_STRAP, ~strap);
        rd(`SCC_OFF_REL, {VER, IDENT});
        rd(`SCC_OFF_STRAP, strap);
        access(1'b1, `SCC_OFF_PSC, 16'hFFFF);
        rd(`SCC_OFF_PSC, 16'hCF07);
        access(1'b1, `SCC_OFF_RELOC, 16'hFFFF);
        rd(`SCC_OFF_RELOC, 16'h7FFF);
        check(icu_slave_mode, 1'b1);
        // io base keeps top bits zero
        access(1'b1, `SCC_OFF_RELOC, 16'h20FF);
        access(1'b1, `SCC_OFF_PSC, 16'h0000);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check(icu_slave_mode, 1'b0);
        dec({12'h0FF, 8'($urandom())}, 1'b0, 2'b11, 3'b111);
        dec({12'h0FF, 8'($urandom())}, 1'b0, 2'b01, 3'b100);
        dec({12'h0FF, 8'h00}, 1'b0, 2'b10, 3'b100);
        dec(20'h0FF10, 1'b1, 2'b00, 3'b011);
        dec(20'h1FF10, 1'b0, 2'b00, 3'b011);
        access(1'b1, `SCC_OFF_RELOC, 16'h1123);
        dec(20'h12345, 1'b1, 2'b00, 3'b100);
        dec(20'h12345, 1'b0, 2'b00, 3'b011);
        @(posedge mclk);
        mfirst <= 1'b0;
        dec(20'h12345, 1'b0, 2'b00, 3'b010);
        access(1'b1, `SCC_OFF_PSC, 16'h4000);
        dec(20'h12345, 1'b0, 2'b00, 3'b011);
        for (int c = 0; c < 8; c++) begin
            access(1'b1, `SCC_OFF_PSC, 16'h8000 | 16'(c));
            period(1 << c);
        end
        access(1'b1, `SCC_OFF_PSC, 16'h0007);
        period(1);
        // external interrupt drops power-save
        access(1'b1, `SCC_OFF_PSC, 16'h8003);
        @(posedge mclk);
        ext_irq <= 1'b1;
        @(posedge mclk);
        ext_irq <= 1'b0;
        rd(`SCC_OFF_PSC, 16'h0003);
        period(1);
        access(1'b1, `SCC_OFF_PSC, 16'h8602);
        period(4);
        toggles(16, 4);
        check({clock_out_a_oe, clock_out_b_oe}, 2'b10);
        access(1'b1, `SCC_OFF_PSC, 16'h8902);
        period(4);
        toggles(4, 16);
        check({clock_out_a_oe, clock_out_b_oe}, 2'b01);
        strap = 16'($urandom());
        do_reset(strap, 1'b0);
        rd(`SCC_OFF_STRAP, strap);
        rd(`SCC_OFF_PSC, 16'h0000);
        check({all_pins_float_test, address_phase_omit, strap_valid}, 3'b111);
        check({clock_out_a_oe, clock_out_b_oe}, 2'b00);
        period(2);
        repeat (4) @(negedge mclk);
        check(16'(q.size()), 16'h0000);
        end_of_test();
    end
endmodule
